//--- blm_pkg.sv
package blm_pkg;

	// Lite port widths: 32-bit address and data, one strobe per byte lane.
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int PROT_W = 3;
	localparam int RESP_W = 2;

	// Response codes carried back to the return FIFO unchanged.
	localparam logic [RESP_W-1:0] RESP_OKAY   = 2'h0;
	localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
	localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
	localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;

	// Protection code bit positions on each address channel.
	localparam int PROT_PRIV_BIT   = 0;
	localparam int PROT_NONSEC_BIT = 1;
	localparam int PROT_INSTR_BIT  = 2;

	// Reset values of the control flops.
	localparam logic VALID_RST = 1'b0;
	localparam logic READY_RST = 1'b0;

	// One access replayed from the link, as read out of the request FIFO.
	typedef struct packed {
		logic              is_write;
		logic [ADDR_W-1:0] addr;
		logic [PROT_W-1:0] prot;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} blm_req_s;

	// One response written into the return FIFO.
	typedef struct packed {
		logic              is_write;
		logic [RESP_W-1:0] resp;
		logic [DATA_W-1:0] data;
	} blm_rsp_s;

	// Sequencer states of the master port.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_ADDR,
		ST_WR_RESP,
		ST_RD_ADDR,
		ST_RD_DATA,
		ST_RETURN
	} blm_state_e;

endpackage

//--- blm_lite_master.sv
`timescale 1ns/10ps
// Behaviour
// - Port active only in lite slave mode.
// - Hold write address and prot until AWREADY.
// - Hold read address and prot until ARREADY.
// - AWVALID high only with valid address.
// - Write and read data are 32 bits.
// - One strobe bit per byte lane.
// - WVALID high only with valid data.
// - Three-bit protection code per address channel.
// - BREADY high when bridge can take response.
// - Response codes go to return FIFO.
// - RREADY high when bridge can take data.
module blm_lite_master (
	// Clock, reset and enable.
	input  wire logic                         clock,
	input  wire logic                         sys_rst,
	input  wire logic                         clk_en,
	// Configuration.
	input  wire logic                         lite_slave_mode,
	// Request FIFO read side.
	input  wire logic                         req_valid,
	input  wire blm_pkg::blm_req_s            req,
	output logic                              req_ready,
	// Return FIFO write side.
	output logic                              rsp_valid,
	output blm_pkg::blm_rsp_s                 rsp,
	input  wire logic                         rsp_ready,
	// Write address channel.
	output logic [blm_pkg::ADDR_W-1:0]        m_axi_lite_awaddr,
	output logic [blm_pkg::PROT_W-1:0]        m_axi_lite_awprot,
	output logic                              m_axi_lite_awvalid,
	input  wire logic                         m_axi_lite_awready,
	// Write data channel.
	output logic [blm_pkg::DATA_W-1:0]        m_axi_lite_wdata,
	output logic [blm_pkg::STRB_W-1:0]        m_axi_lite_wstrb,
	output logic                              m_axi_lite_wvalid,
	input  wire logic                         m_axi_lite_wready,
	// Write response channel.
	input  wire logic [blm_pkg::RESP_W-1:0]   m_axi_lite_bresp,
	input  wire logic                         m_axi_lite_bvalid,
	output logic                              m_axi_lite_bready,
	// Read address channel.
	output logic [blm_pkg::ADDR_W-1:0]        m_axi_lite_araddr,
	output logic [blm_pkg::PROT_W-1:0]        m_axi_lite_arprot,
	output logic                              m_axi_lite_arvalid,
	input  wire logic                         m_axi_lite_arready,
	// Read data channel.
	input  wire logic [blm_pkg::DATA_W-1:0]   m_axi_lite_rdata,
	input  wire logic [blm_pkg::RESP_W-1:0]   m_axi_lite_rresp,
	input  wire logic                         m_axi_lite_rvalid,
	output logic                              m_axi_lite_rready
);

	blm_pkg::blm_state_e state_q;
	blm_pkg::blm_req_s   req_q;
	blm_pkg::blm_rsp_s   rsp_q;
	logic                req_ready_q;
	logic                rsp_valid_q;
	logic                awvalid_q;
	logic                wvalid_q;
	logic                bready_q;
	logic                arvalid_q;
	logic                rready_q;

	// Handshake decode; a transfer counts only on an enabled edge.
	wire req_fire = clk_en & req_valid & req_ready_q;
	wire aw_fire  = awvalid_q & m_axi_lite_awready;
	wire w_fire   = wvalid_q & m_axi_lite_wready;
	wire b_fire   = bready_q & m_axi_lite_bvalid;
	wire ar_fire  = arvalid_q & m_axi_lite_arready;
	wire r_fire   = rready_q & m_axi_lite_rvalid;
	wire rsp_fire = rsp_valid_q & rsp_ready;
	// Address and data phases may finish in either order or together.
	wire aw_done  = ~awvalid_q | aw_fire;
	wire w_done   = ~wvalid_q | w_fire;

	// The captured request drives both address channels; only one is valid at a time.
	assign m_axi_lite_awaddr  = req_q.addr;
	assign m_axi_lite_awprot  = req_q.prot;
	assign m_axi_lite_araddr  = req_q.addr;
	assign m_axi_lite_arprot  = req_q.prot;
	assign m_axi_lite_wdata   = req_q.data;
	assign m_axi_lite_wstrb   = req_q.strb;
	assign m_axi_lite_awvalid = awvalid_q;
	assign m_axi_lite_wvalid  = wvalid_q;
	assign m_axi_lite_bready  = bready_q;
	assign m_axi_lite_arvalid = arvalid_q;
	assign m_axi_lite_rready  = rready_q;
	assign req_ready          = req_ready_q;
	assign rsp_valid          = rsp_valid_q;
	assign rsp                = rsp_q;

	// Request capture; the register only loads in idle, so the address holds for the whole access.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_q <= '0;
		end else if (req_fire) begin
			req_q <= req;
		end
	end

	// Request FIFO ready; a new access is only taken in slave mode while idle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_ready_q <= blm_pkg::READY_RST;
		end else if (clk_en) begin
			req_ready_q <= lite_slave_mode & (state_q == blm_pkg::ST_IDLE) & ~req_fire;
		end
	end

	// Channel sequencer. One access is outstanding at a time, which keeps the
	// return order trivially equal to the request order at the cost of throughput.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q     <= blm_pkg::ST_IDLE;
			awvalid_q   <= blm_pkg::VALID_RST;
			wvalid_q    <= blm_pkg::VALID_RST;
			bready_q    <= blm_pkg::READY_RST;
			arvalid_q   <= blm_pkg::VALID_RST;
			rready_q    <= blm_pkg::READY_RST;
			rsp_valid_q <= blm_pkg::VALID_RST;
			rsp_q       <= '0;
		end else if (clk_en) begin
			case (state_q)
				blm_pkg::ST_IDLE: begin
					if (req_fire && req.is_write) begin
						awvalid_q <= 1'b1;
						wvalid_q  <= 1'b1;
						state_q   <= blm_pkg::ST_WR_ADDR;
					end else if (req_fire) begin
						arvalid_q <= 1'b1;
						state_q   <= blm_pkg::ST_RD_ADDR;
					end
				end
				blm_pkg::ST_WR_ADDR: begin
					if (aw_fire) begin
						awvalid_q <= 1'b0;
					end
					if (w_fire) begin
						wvalid_q <= 1'b0;
					end
					if (aw_done && w_done) begin
						bready_q <= 1'b1;
						state_q  <= blm_pkg::ST_WR_RESP;
					end
				end
				blm_pkg::ST_WR_RESP: begin
					if (b_fire) begin
						bready_q    <= 1'b0;
						rsp_valid_q <= 1'b1;
						rsp_q       <= '{1'b1, m_axi_lite_bresp, '0};
						state_q     <= blm_pkg::ST_RETURN;
					end
				end
				blm_pkg::ST_RD_ADDR: begin
					if (ar_fire) begin
						arvalid_q <= 1'b0;
						rready_q  <= 1'b1;
						state_q   <= blm_pkg::ST_RD_DATA;
					end
				end
				blm_pkg::ST_RD_DATA: begin
					if (r_fire) begin
						rready_q    <= 1'b0;
						rsp_valid_q <= 1'b1;
						rsp_q       <= '{1'b0, m_axi_lite_rresp, m_axi_lite_rdata};
						state_q     <= blm_pkg::ST_RETURN;
					end
				end
				blm_pkg::ST_RETURN: begin
					// The return FIFO may back-pressure; the response is held until taken.
					if (rsp_fire) begin
						rsp_valid_q <= 1'b0;
						state_q     <= blm_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= blm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Checks on the port's own behaviour.
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	aw_hold_a: assert property (m_axi_lite_awvalid && !m_axi_lite_awready |=>
		m_axi_lite_awvalid && $stable(m_axi_lite_awaddr) && $stable(m_axi_lite_awprot))
		else $error("Write address changed before it was accepted.");

	ar_hold_a: assert property (m_axi_lite_arvalid && !m_axi_lite_arready |=>
		m_axi_lite_arvalid && $stable(m_axi_lite_araddr) && $stable(m_axi_lite_arprot))
		else $error("Read address changed before it was accepted.");

	w_hold_a: assert property (m_axi_lite_wvalid && !m_axi_lite_wready |=>
		m_axi_lite_wvalid && $stable(m_axi_lite_wdata) && $stable(m_axi_lite_wstrb))
		else $error("Write data dropped or changed before it was accepted.");

	aw_drop_a: assert property (m_axi_lite_awvalid && m_axi_lite_awready && clk_en |=>
		!m_axi_lite_awvalid)
		else $error("Write address valid stayed high after its transfer.");

	wr_issue_a: assert property (req_valid && req_ready && clk_en && req.is_write |=>
		m_axi_lite_awvalid && m_axi_lite_wvalid
		&& m_axi_lite_wstrb == $past(req.strb) && m_axi_lite_awaddr == $past(req.addr))
		else $error("Write request was not issued on both channels next cycle.");

	b_return_a: assert property (m_axi_lite_bvalid && m_axi_lite_bready && clk_en |=>
		rsp_valid && rsp.is_write && rsp.resp == $past(m_axi_lite_bresp) && !m_axi_lite_bready)
		else $error("Write response not passed to the return FIFO.");

	r_return_a: assert property (m_axi_lite_rvalid && m_axi_lite_rready && clk_en |=>
		rsp_valid && !rsp.is_write && rsp.resp == $past(m_axi_lite_rresp)
		&& rsp.data == $past(m_axi_lite_rdata))
		else $error("Read response not passed to the return FIFO.");

	rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
		else $error("Return data dropped before the FIFO took it.");

	mode_gate_a: assert property (!lite_slave_mode && clk_en |=> !req_ready)
		else $error("Request taken while the port is not in slave mode.");

	b_wait_a: assert property (m_axi_lite_bready && !m_axi_lite_bvalid && clk_en |=>
		m_axi_lite_bready && !rsp_valid)
		else $error("Response ready withdrawn before a response arrived.");

endmodule

//--- blm_slave_model.sv
`timescale 1ns/10ps
module blm_slave_model (
	// Clock and bench controls.
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [1:0]  stall,
	input  wire logic [1:0]  resp_code,
	input  wire logic [31:0] rd_word,
	// Address and data channels from the port.
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// Response channels back to the port.
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// What the slave saw, for the bench.
	output logic [31:0]      cap_addr,
	output logic [2:0]       cap_prot,
	output logic [31:0]      cap_data,
	output logic [3:0]       cap_strb
);
	logic got_aw, got_w, got_ar;

	// Readiness follows the stall lines, so both prompt and slow slaves are seen.
	// Data has its own stall bit so address and data are accepted in either order.
	assign awready = !stall[0];
	assign arready = !stall[0];
	assign wready  = !stall[1];
	assign bresp   = resp_code;
	assign rresp   = resp_code;
	// Idle read data shows a changed word so a stale capture cannot match.
	assign rdata   = rvalid ? rd_word : ~rd_word;

	// Captures on each handshake and answers one access at a time.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			got_aw <= 1'b0;
			got_w <= 1'b0;
			got_ar <= 1'b0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
		end else if (clk_en) begin
			if (awvalid && awready) begin
				got_aw <= 1'b1;
				cap_addr <= awaddr;
				cap_prot <= awprot;
			end
			if (wvalid && wready) begin
				got_w <= 1'b1;
				cap_data <= wdata;
				cap_strb <= wstrb;
			end
			if (arvalid && arready) begin
				got_ar <= 1'b1;
				cap_addr <= araddr;
				cap_prot <= arprot;
			end
			if (got_aw && got_w && !stall[0]) bvalid <= 1'b1;
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				got_aw <= 1'b0;
				got_w <= 1'b0;
			end
			if (got_ar && !stall[0]) rvalid <= 1'b1;
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				got_ar <= 1'b0;
			end
		end
	end
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic              clock, sys_rst, clk_en, lite_slave_mode, rnd_on;
	logic [1:0]        stall;
	logic              req_valid, req_ready, rsp_valid, rsp_ready;
	blm_pkg::blm_req_s req;
	blm_pkg::blm_rsp_s rsp;
	logic [31:0]       awaddr, wdata, araddr, rdata, cap_addr, cap_data, rd_word;
	logic [2:0]        awprot, arprot, cap_prot;
	logic [3:0]        wstrb, cap_strb;
	logic [1:0]        bresp, rresp, resp_code;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	int                errors, n_checks, i;

	blm_lite_master blm_lite_master_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.lite_slave_mode(lite_slave_mode), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_ready(rsp_ready),
		.m_axi_lite_awaddr(awaddr), .m_axi_lite_awprot(awprot), .m_axi_lite_awvalid(awvalid),
		.m_axi_lite_awready(awready), .m_axi_lite_wdata(wdata), .m_axi_lite_wstrb(wstrb),
		.m_axi_lite_wvalid(wvalid), .m_axi_lite_wready(wready), .m_axi_lite_bresp(bresp),
		.m_axi_lite_bvalid(bvalid), .m_axi_lite_bready(bready), .m_axi_lite_araddr(araddr),
		.m_axi_lite_arprot(arprot), .m_axi_lite_arvalid(arvalid),
		.m_axi_lite_arready(arready), .m_axi_lite_rdata(rdata), .m_axi_lite_rresp(rresp),
		.m_axi_lite_rvalid(rvalid), .m_axi_lite_rready(rready));

	blm_slave_model blm_slave_model_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
		.stall(stall), .resp_code(resp_code), .rd_word(rd_word), .awaddr(awaddr),
		.awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .araddr(araddr), .arprot(arprot),
		.arvalid(arvalid), .arready(arready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cap_addr(cap_addr), .cap_prot(cap_prot), .cap_data(cap_data), .cap_strb(cap_strb));

	// Free-running bench clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Random stalls, clock enables and return back-pressure, once the directed accesses are done.
	always @(negedge clock) begin
		if (rnd_on) begin
			stall = 2'($urandom);
			rsp_ready = 1'($urandom);
			clk_en = ($urandom % 4) != 0;
		end
	end

	task automatic summarize;
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A wait that runs out of cycles ends the run.
	task automatic wait_for(input logic is_req);
		int k;
		for (k = 0; k < 300; k++) begin
			@(posedge clock);
			if (clk_en && (is_req ? req_ready : (rsp_valid && rsp_ready))) break;
		end
		if (k >= 300) begin
			errors++;
			$display("BAD %0t handshake timeout", $time);
			summarize();
		end
	endtask

	// One access from the request side, checked at the slave and at the return side.
	task automatic access(input logic w, input logic [31:0] a, input logic [2:0] p,
		input logic [31:0] d, input logic [3:0] s, input logic [1:0] rc);
		@(negedge clock);
		req = '{w, a, p, d, s};
		resp_code = rc;
		rd_word = d;
		req_valid = 1'b1;
		wait_for(1'b1);
		@(negedge clock);
		req_valid = 1'b0;
		wait_for(1'b0);
		check(rsp, {w, rc, w ? 32'h0 : d});
		check({cap_addr, cap_prot}, {a, p});
		if (w) check({cap_data, cap_strb}, {d, s});
	endtask

	initial begin
		{errors, n_checks, rnd_on, stall, req_valid} = '0;
		{clk_en, sys_rst, rsp_ready} = 3'h7;
		{lite_slave_mode, resp_code, rd_word} = '0;
		req = '0;
		void'($urandom(77));
		repeat (10) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'b0;
		// A pending request must stay untouched while the port is not in slave mode.
		req_valid = 1'b1;
		for (i = 0; i < 20; i++) begin
			@(negedge clock);
			check(req_ready, 1'b0);
		end
		@(negedge clock);
		lite_slave_mode = 1'b1;
		// Every response code both ways, back to back, with edge addresses.
		for (i = 0; i < 8; i++)
			access(i[0], {30'h3fff_ffff ^ i[29:0], 2'h0}, i[2:0], 32'ha5a5_0000 | i, i[3:0], i[2:1]);
		rnd_on = 1'b1;
		for (i = 0; i < 60; i++)
			access(1'($urandom), $urandom, 3'($urandom), $urandom, 4'($urandom), 2'($urandom));
		summarize();
	end
endmodule
